// File: rtl/stug_top.sv
// scan test update gating: section update enables, reset handling, RAM shift guards
//
// Function
// - trace flops frozen when test and gate low
// - vector flops frozen when test and gate low
// - other core flops frozen when test and gate low
// - gate high lets its section update
// - gates ignored outside both test modes
// - internal resets come from flip-flops
// - scan shift blocks internal reset assertion
// - separate shift guard per RAM unit
// - guards force L1 RAM selects inactive
// - level2 guard stops level2 RAM clock
// - gated RAM clock skips RAM scan chains
// - wrapper cells hold in test mode without shift or capture
`default_nettype none
module stug_top
  import stug_pkg::*;
#(
  parameter int NRST = STUG_NUM_RST
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            pclk_en,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic      [31:0]     prdata,
  output logic                 pslverr,
  // tester pins
  input  wire logic            memory_selftest_active,
  input  wire logic            scan_test_active,
  input  wire logic            trace_section_update_gate,
  input  wire logic            vector_section_update_gate,
  input  wire logic            core_section_update_gate,
  input  wire logic            scan_shift_enable,
  input  wire logic            fetch_ram_shift_guard,
  input  wire logic            loadstore_ram_shift_guard,
  input  wire logic            level2_ram_shift_guard,
  input  wire logic            wrapper_shift,
  input  wire logic            wrapper_capture,
  // core-side requests on pclk
  input  wire logic            fetch_ram_cs_req,
  input  wire logic            fetch_ram_we_req,
  input  wire logic            loadstore_ram_cs_req,
  input  wire logic            loadstore_ram_we_req,
  input  wire logic [NRST-1:0] core_reset_req,
  // gated outputs
  output logic                 trace_update_en,
  output logic                 vector_update_en,
  output logic                 core_update_en,
  output logic      [NRST-1:0] internal_reset_n,
  output logic                 fetch_ram_cs,
  output logic                 fetch_ram_we,
  output logic                 loadstore_ram_cs,
  output logic                 loadstore_ram_we,
  output logic                 level2_ram_clk_en,
  output logic                 wrapper_hold
);

  typedef struct packed {
    logic [NRST-1:0] ctrl;
    logic [31:0]     scratch;
    logic            pready;
    logic [31:0]     prdata;
    logic            pslverr;
    logic            trace_en;
    logic            vector_en;
    logic            core_en;
    logic [NRST-1:0] rst_n;
    logic            if_cs;
    logic            if_we;
    logic            ls_cs;
    logic            ls_we;
    logic            l2_clk_en;
    logic            whold;
  } stug_state_s;

  localparam stug_state_s STATE_RST = '{
    ctrl:      '0,
    scratch:   STUG_SCRATCH_RST,
    pready:    1'b0,
    prdata:    STUG_RDATA_RST,
    pslverr:   1'b0,
    trace_en:  1'b1,
    vector_en: 1'b1,
    core_en:   1'b1,
    rst_n:     '1,
    if_cs:     1'b0,
    if_we:     1'b0,
    ls_cs:     1'b0,
    ls_we:     1'b0,
    l2_clk_en: 1'b1,
    whold:     1'b0
  };

  stug_state_s              state_q;
  stug_state_s              state_d;
  logic [STUG_NUM_PINS-1:0] pin_raw;
  logic [STUG_NUM_PINS-1:0] pin_s;
  logic                     test_mode;
  logic                     shift_s;
  logic [31:0]              status_w;

  // a section updates unless a test mode is on and its gate is low
  function automatic logic sect_en(input logic test, input logic gate);
    return !test || gate;
  endfunction

  assign pin_raw[STUG_PIN_MBIST]  = memory_selftest_active;
  assign pin_raw[STUG_PIN_SCAN]   = scan_test_active;
  assign pin_raw[STUG_PIN_EGATE]  = trace_section_update_gate;
  assign pin_raw[STUG_PIN_NGATE]  = vector_section_update_gate;
  assign pin_raw[STUG_PIN_CGATE]  = core_section_update_gate;
  assign pin_raw[STUG_PIN_SHIFT]  = scan_shift_enable;
  assign pin_raw[STUG_PIN_IFG]    = fetch_ram_shift_guard;
  assign pin_raw[STUG_PIN_LSG]    = loadstore_ram_shift_guard;
  assign pin_raw[STUG_PIN_L2G]    = level2_ram_shift_guard;
  assign pin_raw[STUG_PIN_WSHIFT] = wrapper_shift;
  assign pin_raw[STUG_PIN_WCAP]   = wrapper_capture;

  stug_sync #(
    .W (STUG_NUM_PINS)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pclk_en (pclk_en),
    .pin_in  (pin_raw),
    .pin_q   (pin_s)
  );

  assign test_mode = pin_s[STUG_PIN_MBIST] | pin_s[STUG_PIN_SCAN];
  assign shift_s   = pin_s[STUG_PIN_SHIFT];

  always_comb
  begin
    status_w                 = '0;
    status_w[STUG_ST_MBIST]  = pin_s[STUG_PIN_MBIST];
    status_w[STUG_ST_SCAN]   = pin_s[STUG_PIN_SCAN];
    status_w[STUG_ST_SHIFT]  = shift_s;
    status_w[STUG_ST_TRACE]  = state_q.trace_en;
    status_w[STUG_ST_VECTOR] = state_q.vector_en;
    status_w[STUG_ST_CORE]   = state_q.core_en;
    status_w[STUG_ST_L2CLK]  = state_q.l2_clk_en;
    status_w[STUG_ST_HOLD]   = state_q.whold;
    status_w[STUG_ST_RSTN +: NRST] = state_q.rst_n;
  end

  always_comb
  begin
    state_d         = state_q;
    state_d.pready  = 1'b0;
    state_d.pslverr = 1'b0;

    // apb: answer in the second access cycle, pready pulses for one cycle
    if (psel && penable && !state_q.pready)
    begin
      state_d.pready = 1'b1;
      unique case (paddr)
        STUG_OFF_CTRL:
        begin
          if (pwrite)
          begin
            state_d.ctrl = pwdata[STUG_CTRL_RST_POS +: NRST];
          end
          state_d.prdata = {{(32-NRST){1'b0}}, state_q.ctrl};
        end
        STUG_OFF_SCRATCH:
        begin
          // scratch is a core-section flop: a blocked write leaves it unchanged
          if (pwrite && state_q.core_en)
          begin
            state_d.scratch = pwdata;
          end
          state_d.prdata = state_q.scratch;
        end
        STUG_OFF_STATUS:
        begin
          state_d.prdata = status_w;
        end
        default:
        begin
          state_d.prdata  = '0;
          state_d.pslverr = 1'b1;
        end
      endcase
    end

    // section update enables; outside test mode the gates are don't-care
    state_d.trace_en  = sect_en(test_mode, pin_s[STUG_PIN_EGATE]);
    state_d.vector_en = sect_en(test_mode, pin_s[STUG_PIN_NGATE]);
    state_d.core_en   = sect_en(test_mode, pin_s[STUG_PIN_CGATE]);

    // resets leave a flop so no combinational glitch reaches async pins;
    // while shifting they are held released so scanned data survives
    state_d.rst_n = {NRST{shift_s}} | ~(state_q.ctrl | core_reset_req);

    // one guard per unit; a guard tied low folds its gate away in synthesis
    state_d.if_cs = fetch_ram_cs_req & ~pin_s[STUG_PIN_IFG];
    state_d.if_we = fetch_ram_we_req & ~pin_s[STUG_PIN_IFG];
    state_d.ls_cs = loadstore_ram_cs_req & ~pin_s[STUG_PIN_LSG];
    state_d.ls_we = loadstore_ram_we_req & ~pin_s[STUG_PIN_LSG];
    // stopping the level2 RAM clock also freezes any chain inside the RAM
    state_d.l2_clk_en = ~pin_s[STUG_PIN_L2G];

    // wrapper cells hold in test mode unless shifting or capturing
    state_d.whold = test_mode & ~pin_s[STUG_PIN_WSHIFT]
                  & ~pin_s[STUG_PIN_WCAP];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= STATE_RST;
    end
    else if (pclk_en)
    begin
      state_q <= state_d;
    end
  end

  assign pready            = state_q.pready;
  assign prdata            = state_q.prdata;
  assign pslverr           = state_q.pslverr;
  assign trace_update_en   = state_q.trace_en;
  assign vector_update_en  = state_q.vector_en;
  assign core_update_en    = state_q.core_en;
  assign internal_reset_n  = state_q.rst_n;
  assign fetch_ram_cs      = state_q.if_cs;
  assign fetch_ram_we      = state_q.if_we;
  assign loadstore_ram_cs  = state_q.ls_cs;
  assign loadstore_ram_we  = state_q.ls_we;
  assign level2_ram_clk_en = state_q.l2_clk_en;
  assign wrapper_hold      = state_q.whold;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_trace_block;
    pclk_en && test_mode && !pin_s[STUG_PIN_EGATE] |=> !trace_update_en;
  endproperty
  a_trace_block: assert property (p_trace_block)
    else $error("trace section updated while its gate was low");

  property p_vector_block;
    pclk_en && test_mode && !pin_s[STUG_PIN_NGATE] |=> !vector_update_en;
  endproperty
  a_vector_block: assert property (p_vector_block)
    else $error("vector section updated while its gate was low");

  property p_core_block;
    pclk_en && test_mode && !pin_s[STUG_PIN_CGATE] |=> !core_update_en;
  endproperty
  a_core_block: assert property (p_core_block)
    else $error("core section updated while its gate was low");

  property p_gate_high;
    pclk_en && pin_s[STUG_PIN_EGATE] && pin_s[STUG_PIN_NGATE] && pin_s[STUG_PIN_CGATE]
      |=> trace_update_en && vector_update_en && core_update_en;
  endproperty
  a_gate_high: assert property (p_gate_high)
    else $error("section blocked although its gate was high");

  property p_no_test;
    (pclk_en && !test_mode) [*2] |=> trace_update_en && vector_update_en && core_update_en;
  endproperty
  a_no_test: assert property (p_no_test)
    else $error("section gated outside test mode");

  property p_rst_flop;
    !$stable(internal_reset_n) |-> $past(pclk_en);
  endproperty
  a_rst_flop: assert property (p_rst_flop)
    else $error("internal reset changed without a clock enable");

  property p_shift_rst;
    pclk_en && shift_s |=> &internal_reset_n;
  endproperty
  a_shift_rst: assert property (p_shift_rst)
    else $error("internal reset asserted during scan shift");

  property p_fetch_guard;
    pclk_en && pin_s[STUG_PIN_IFG] |=> !fetch_ram_cs && !fetch_ram_we;
  endproperty
  a_fetch_guard: assert property (p_fetch_guard)
    else $error("fetch RAM selected during safe shift");

  property p_ls_guard;
    pclk_en && pin_s[STUG_PIN_LSG] |=> !loadstore_ram_cs && !loadstore_ram_we;
  endproperty
  a_ls_guard: assert property (p_ls_guard)
    else $error("load/store RAM selected during safe shift");

  property p_l2_clk;
    pclk_en && pin_s[STUG_PIN_L2G] |=> !level2_ram_clk_en;
  endproperty
  a_l2_clk: assert property (p_l2_clk)
    else $error("level2 RAM clock running during safe shift");

  property p_wrap_hold;
    pclk_en && test_mode && !pin_s[STUG_PIN_WSHIFT] && !pin_s[STUG_PIN_WCAP]
      |=> wrapper_hold;
  endproperty
  a_wrap_hold: assert property (p_wrap_hold)
    else $error("wrapper cells not held while idle in test mode");

  property p_scratch_hold;
    pclk_en && !state_q.core_en |=> $stable(state_q.scratch);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("blocked core flop changed value");

  property p_apb_answer;
    pclk_en && psel && penable && !pready |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb access not answered in one cycle");

  property p_unmapped;
    pclk_en && psel && penable && !pready && (paddr != STUG_OFF_CTRL)
      && (paddr != STUG_OFF_SCRATCH) && (paddr != STUG_OFF_STATUS) |=> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped apb access answered without an error");

  property p_rst_req;
    pclk_en && !shift_s && core_reset_req[0] |=> !internal_reset_n[0];
  endproperty
  a_rst_req: assert property (p_rst_req)
    else $error("reset request did not reach the internal reset flop");

  property p_freeze;
    !pclk_en |=> $stable(state_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state changed while the clock enable was low");

endmodule
`default_nettype wire

// File: rtl/stug_pkg.sv
// constants shared by the scan test update gating block
`default_nettype none
package stug_pkg;
  // register byte offsets
  localparam logic [11:0] STUG_OFF_CTRL    = 12'h000;
  localparam logic [11:0] STUG_OFF_SCRATCH = 12'h004;
  localparam logic [11:0] STUG_OFF_STATUS  = 12'h008;
  // values after reset
  localparam logic [31:0] STUG_SCRATCH_RST = 32'h0000_0000;
  localparam logic [31:0] STUG_RDATA_RST   = 32'h0000_0000;
  // number of internal reset outputs
  localparam int STUG_NUM_RST = 2;
  // ctrl: one software reset request bit per internal reset, from bit 0
  localparam int STUG_CTRL_RST_POS = 0;
  // status field positions
  localparam int STUG_ST_MBIST   = 0;
  localparam int STUG_ST_SCAN    = 1;
  localparam int STUG_ST_SHIFT   = 2;
  localparam int STUG_ST_TRACE   = 3;
  localparam int STUG_ST_VECTOR  = 4;
  localparam int STUG_ST_CORE    = 5;
  localparam int STUG_ST_L2CLK   = 6;
  localparam int STUG_ST_HOLD    = 7;
  localparam int STUG_ST_RSTN    = 8;
  // indices into the synchronised pin vector
  localparam int STUG_PIN_MBIST  = 0;
  localparam int STUG_PIN_SCAN   = 1;
  localparam int STUG_PIN_EGATE  = 2;
  localparam int STUG_PIN_NGATE  = 3;
  localparam int STUG_PIN_CGATE  = 4;
  localparam int STUG_PIN_SHIFT  = 5;
  localparam int STUG_PIN_IFG    = 6;
  localparam int STUG_PIN_LSG    = 7;
  localparam int STUG_PIN_L2G    = 8;
  localparam int STUG_PIN_WSHIFT = 9;
  localparam int STUG_PIN_WCAP   = 10;
  localparam int STUG_NUM_PINS   = 11;
  // synchroniser depth for pin inputs
  localparam int STUG_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// File: rtl/stug_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module stug_sync
  import stug_pkg::*;
#(
  parameter int W = STUG_NUM_PINS
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         pclk_en,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } stug_sync_s;

  stug_sync_s state_q;
  stug_sync_s state_d;

  always_comb
  begin
    state_d    = state_q;
    state_d.s1 = pin_in;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    // a bit moves only when the two older stages match, so one glitch is ignored
    state_d.q  = (~(state_q.s2 ^ state_q.s3) & state_q.s2)
               | ((state_q.s2 ^ state_q.s3) & state_q.q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= '0;
    end
    else if (pclk_en)
    begin
      state_q <= state_d;
    end
  end

  assign pin_q = state_q.q;

endmodule
`default_nettype wire

// File: verif/stug_tester.sv
// tester model that drives the scan and self-test pins of the gating block
`default_nettype none
module stug_tester
  import stug_pkg::*;
#(
  parameter logic [2:0] TIE_LOW = 3'b000
)
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [STUG_NUM_PINS-1:0] pin_cmd,
  output logic      [STUG_NUM_PINS-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [STUG_NUM_PINS-1:0] pins_d;
  always_comb
  begin
    pins_d = pin_cmd;
    // a real tester never shifts with the RAMs unguarded
    if (pin_cmd[STUG_PIN_SHIFT])
      pins_d[STUG_PIN_L2G:STUG_PIN_IFG] = 3'b111;
    // a unit whose guard is tied low sees no guard at all
    pins_d[STUG_PIN_L2G:STUG_PIN_IFG] &= ~TIE_LOW;
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pins <= '0;
    else
      pins <= pins_d;
endmodule
`default_nettype wire

// File: verif/stug_top_tb_top.sv
// self-checking testbench for the scan test update gating block
`default_nettype none
module stug_top_tb_top
  import stug_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     pclk;
  logic                     presetn;
  logic                     pclk_en;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic [STUG_NUM_PINS-1:0] pin_cmd;
  logic [STUG_NUM_PINS-1:0] pins;
  logic                     fetch_ram_cs_req;
  logic                     fetch_ram_we_req;
  logic                     loadstore_ram_cs_req;
  logic                     loadstore_ram_we_req;
  logic [STUG_NUM_RST-1:0]  core_reset_req;
  logic                     trace_update_en;
  logic                     vector_update_en;
  logic                     core_update_en;
  logic [STUG_NUM_RST-1:0]  internal_reset_n;
  logic                     fetch_ram_cs;
  logic                     fetch_ram_we;
  logic                     loadstore_ram_cs;
  logic                     loadstore_ram_we;
  logic                     level2_ram_clk_en;
  logic                     wrapper_hold;
  int                       miscompares;
  int                       checks_done;
  int                       cycles;

  stug_tester i_stug_tester (.pclk, .presetn, .pin_cmd, .pins);
  stug_top #(.NRST(STUG_NUM_RST)) i_stug_top (
    .pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr,
    .memory_selftest_active(pins[STUG_PIN_MBIST]), .scan_test_active(pins[STUG_PIN_SCAN]),
    .trace_section_update_gate(pins[STUG_PIN_EGATE]),
    .vector_section_update_gate(pins[STUG_PIN_NGATE]),
    .core_section_update_gate(pins[STUG_PIN_CGATE]), .scan_shift_enable(pins[STUG_PIN_SHIFT]),
    .fetch_ram_shift_guard(pins[STUG_PIN_IFG]), .loadstore_ram_shift_guard(pins[STUG_PIN_LSG]),
    .level2_ram_shift_guard(pins[STUG_PIN_L2G]), .wrapper_shift(pins[STUG_PIN_WSHIFT]),
    .wrapper_capture(pins[STUG_PIN_WCAP]), .fetch_ram_cs_req, .fetch_ram_we_req,
    .loadstore_ram_cs_req, .loadstore_ram_we_req, .core_reset_req, .trace_update_en,
    .vector_update_en, .core_update_en, .internal_reset_n, .fetch_ram_cs, .fetch_ram_we,
    .loadstore_ram_cs, .loadstore_ram_we, .level2_ram_clk_en, .wrapper_hold);

  always #4 pclk = ~pclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the ceiling of 20000 cycles is over twenty times the length of the full sequence, roughly 650 cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // pins pass the tester flop and the synchroniser before the outputs move
  task automatic pins_to(input logic [STUG_NUM_PINS-1:0] v);
    @(posedge pclk);
    pin_cmd <= v;
    wait_n(9);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout may end a stalled access
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk("write error", 32'h0000_0000, {31'h0, er});
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(nm, exp, rd);
    chk("read error", 32'h0000_0000, {31'h0, er});
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic        er;
    wait_n(1);
    chk("outputs", 32'h0000_07C2, {21'h0, trace_update_en, vector_update_en, core_update_en,
        internal_reset_n, fetch_ram_cs, fetch_ram_we, loadstore_ram_cs, loadstore_ram_we,
        level2_ram_clk_en, wrapper_hold});
    rd_chk("ctrl", STUG_OFF_CTRL, 32'h0000_0000);
    rd_chk("scratch", STUG_OFF_SCRATCH, STUG_SCRATCH_RST);
    rd_chk("status", STUG_OFF_STATUS, 32'h0000_0378);
    apb(1'b0, 12'h00C, 32'h0000_0000, rd, er);
    chk("unmapped error", 32'h0000_0001, {31'h0, er});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  task automatic t_gates();
    logic [STUG_NUM_PINS-1:0] v;
    logic [31:0]              upd;
    for (int m = 0; m < 4; m++)
      for (int g = 0; g < 8; g++)
      begin
        v = '0;
        v[STUG_PIN_MBIST] = m[0];
        v[STUG_PIN_SCAN] = m[1];
        v[STUG_PIN_EGATE] = g[0];
        v[STUG_PIN_NGATE] = g[1];
        v[STUG_PIN_CGATE] = g[2];
        pins_to(v);
        upd = {29'h0, core_update_en, vector_update_en, trace_update_en};
        // mode 0 shows ignored gates, the others blocked and released ones
        chk("update_en", (m == 0) ? 32'h0000_0007 : 32'(g), upd);
      end
    $display("test gates done");
  endtask

  task automatic t_scratch();
    logic [STUG_NUM_PINS-1:0] v;
    v = '0;
    v[STUG_PIN_SCAN] = 1'b1;
    pins_to(v);
    wr(STUG_OFF_SCRATCH, 32'hA5A5_0F0F);
    rd_chk("frozen scratch", STUG_OFF_SCRATCH, 32'h0000_0000);
    wr(STUG_OFF_STATUS, 32'hFFFF_FFFF);
    rd_chk("status", STUG_OFF_STATUS, 32'h0000_03C2);
    v[STUG_PIN_CGATE] = 1'b1;
    pins_to(v);
    wr(STUG_OFF_SCRATCH, 32'hA5A5_0F0F);
    rd_chk("open scratch", STUG_OFF_SCRATCH, 32'hA5A5_0F0F);
    pins_to('0);
    $display("test scratch done");
  endtask

  task automatic t_resets();
    logic [STUG_NUM_PINS-1:0] v;
    @(posedge pclk);
    core_reset_req <= 2'b01;
    wait_n(2);
    chk("reset_n", 32'h0000_0002, {30'h0, internal_reset_n});
    v = '0;
    v[STUG_PIN_SHIFT] = 1'b1;
    pins_to(v);
    chk("reset_n shift", 32'h0000_0003, {30'h0, internal_reset_n});
    wr(STUG_OFF_CTRL, 32'h0000_0002);
    wait_n(2);
    chk("reset_n shift ctrl", 32'h0000_0003, {30'h0, internal_reset_n});
    pins_to('0);
    chk("reset_n ctrl", 32'h0000_0000, {30'h0, internal_reset_n});
    @(posedge pclk);
    core_reset_req <= 2'b00;
    wr(STUG_OFF_CTRL, 32'h0000_0000);
    wait_n(2);
    chk("reset_n idle", 32'h0000_0003, {30'h0, internal_reset_n});
    $display("test resets done");
  endtask

  task automatic t_guards();
    logic [STUG_NUM_PINS-1:0] v;
    logic [31:0]              ram;
    logic [31:0]              exp_ram;
    @(posedge pclk);
    {fetch_ram_cs_req, fetch_ram_we_req, loadstore_ram_cs_req, loadstore_ram_we_req} <= 4'hF;
    for (int g = 0; g < 8; g++)
    begin
      v = '0;
      v[STUG_PIN_L2G:STUG_PIN_IFG] = 3'(g);
      pins_to(v);
      exp_ram = {27'h0, ~g[2], ~g[1], ~g[1], ~g[0], ~g[0]};
      ram = {27'h0, level2_ram_clk_en, loadstore_ram_cs, loadstore_ram_we, fetch_ram_cs,
             fetch_ram_we};
      chk("ram", exp_ram, ram);
    end
    pins_to('0);
    $display("test guards done");
  endtask

  function automatic logic [31:0] outs();
    return {21'h0, trace_update_en, vector_update_en, core_update_en, internal_reset_n,
            fetch_ram_cs, fetch_ram_we, loadstore_ram_cs, loadstore_ram_we, level2_ram_clk_en,
            wrapper_hold};
  endfunction

  // with the clock enable low every output must hold, even as pins and requests move
  task automatic t_freeze();
    logic [STUG_NUM_PINS-1:0] v;
    v = '0;
    v[STUG_PIN_SCAN] = 1'b1;
    @(posedge pclk);
    pclk_en <= 1'b0;
    core_reset_req <= 2'b11;
    pin_cmd <= v;
    wait_n(12);
    chk("frozen outputs", 32'h0000_07FE, outs());
    @(posedge pclk);
    pclk_en <= 1'b1;
    wait_n(9);
    chk("released outputs", 32'h0000_003F, outs());
    @(posedge pclk);
    core_reset_req <= 2'b00;
    pin_cmd <= '0;
    wait_n(9);
    $display("test freeze done");
  endtask

  task automatic t_wrapper();
    logic [STUG_NUM_PINS-1:0] v;
    for (int m = 0; m < 2; m++)
      for (int w = 0; w < 4; w++)
      begin
        v = '0;
        v[STUG_PIN_SCAN] = m[0];
        v[STUG_PIN_WSHIFT] = w[0];
        v[STUG_PIN_WCAP] = w[1];
        pins_to(v);
        chk("hold", {31'h0, m[0] && w == 0}, {31'h0, wrapper_hold});
      end
    $display("test wrapper done");
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    pclk_en = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pin_cmd = '0;
    {fetch_ram_cs_req, fetch_ram_we_req, loadstore_ram_cs_req, loadstore_ram_we_req} = 4'h0;
    core_reset_req = '0;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gates();
    t_scratch();
    t_resets();
    t_guards();
    t_freeze();
    t_wrapper();
    print_verdict();
  end
endmodule
`default_nettype wire
